// *** hw/tcp_map.vh ***
// register offsets, field positions and timing constants of the tape character port
`ifndef TCP_MAP_VH
`define TCP_MAP_VH
// ==================================================================
// register byte offsets
`define TCP_CTRL      8'h00
`define TCP_UNIT      8'h04
`define TCP_INSTR     8'h08
`define TCP_CMD       8'h0c
`define TCP_TXDATA    8'h10
`define TCP_RXDATA    8'h14
`define TCP_STATUS    8'h18
`define TCP_IRQ_STAT  8'h1c
`define TCP_IRQ_MASK  8'h20
// ==================================================================
// control bits
`define TCP_CTRL_GO   0
`define TCP_CTRL_DIR  1
`define TCP_CTRL_STOP 2
// command bits
`define TCP_CMD_BUF   0
`define TCP_CMD_IO    1
`define TCP_CMD_SKIP  2
// interrupt bits
`define TCP_IRQ_CHAR  0
`define TCP_IRQ_HALT  1
`define TCP_IRQ_ERR   2
`define TCP_IRQ_GAP   3
`define TCP_IRQ_PAR   4
`define TCP_IRQ_W     5
// ==================================================================
// reset values and timing
`define TCP_UNIT_RST  5'h00
`define TCP_INSTR_RST 12'h000
`define TCP_PHASE_DIV 4
`define TCP_WIN_FIRST 3'h6
`define TCP_WIN_LAST  3'h3
`define TCP_RESP_OK   2'h0
`define TCP_RESP_ERR  2'h2
`endif

// *** hw/tcp_sync.v ***
// two flip-flop synchroniser for pins from outside the clock domain
module tcp_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] rst_val,
  // pins in, synchronised out
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta     <= rst_val;
      sync_out <= rst_val;
    end else begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end
endmodule

// *** hw/tcp_phase.v ***
// computer cycle phase counter and the t6-through-t3 timing window
`include "tcp_map.vh"
module tcp_phase #(
  parameter DIV = `TCP_PHASE_DIV
) (
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // phase outputs
  output reg  [2:0] phase,
  output reg        phase_step,
  output reg        window
);
  reg  [7:0] div_cnt;
  wire       step = (div_cnt == DIV[7:0] - 8'h01);
  wire [2:0] next_phase = phase + 3'h1;

  // eight phases per cycle, one step every DIV clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt    <= 8'h00;
      phase      <= 3'h0;
      phase_step <= 1'b0;
      window     <= 1'b1;
    end else begin
      div_cnt    <= step ? 8'h00 : div_cnt + 8'h01;
      phase_step <= step;
      if (step) begin
        phase <= next_phase;
        window <= (next_phase >= `TCP_WIN_FIRST) || (next_phase <= `TCP_WIN_LAST);
      end
    end
  end
endmodule

// *** hw/tcp_port.v ***
// tape character channel port: axi4-lite registers, character buffer and pin logic
// ==================================================================
// Overview of operation
// - grounded halt input ends current transfer
// - grounded skip response makes program skip
// - one buffer-control strobe per command
// - one input/output-control strobe per command
// - grounded error input flags an error
// - halt interlock shows characters being processed
// - pending flag set when character move due
// - clock-seen flag set on character clock
// - timing output true t6 through t3
// - direction bit high output, low input
// - unit select bits on dedicated lines
// - six-bit character bus, last line lsb
// - odd parity generated per output character
// - twelve instruction address lines driven out
// - input character lines are inverted levels
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`include "tcp_map.vh"
module tcp_port #(
  parameter DIV = `TCP_PHASE_DIV
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // peripheral inputs, all active low except the clock
  input  wire        halt_n,
  input  wire        skip_resp_n,
  input  wire        error_n,
  input  wire        gap_n,
  input  wire        char_clock,
  input  wire [5:0]  char_in_bus_n,
  input  wire        char_in_parity_n,
  // peripheral outputs
  output reg         buffer_ctl_strobe,
  output reg         io_ctl_strobe,
  output reg         halt_interlock_out,
  output reg         transfer_pending_ff,
  output reg         clock_seen_ff,
  output wire        cycle_window_timing,
  output reg         direction_bit,
  output reg  [4:0]  unit_select_bits,
  output reg  [5:0]  char_out_bus,
  output reg         char_out_parity,
  output reg  [11:0] instr_address_lines,
  // interrupt
  output reg         irq
);
  // ==================================================================
  // helpers
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a <= `TCP_IRQ_MASK) && (a[1:0] == 2'b00);
    end
  endfunction

  // ==================================================================
  // cycle phases
  wire [2:0] phase;
  wire       phase_step;

  tcp_phase #(
    .DIV (DIV)
  ) u_phase (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .phase      (phase),
    .phase_step (phase_step),
    .window     (cycle_window_timing)
  );

  // ==================================================================
  // pin synchronisers
  wire [11:0] pins_s;

  // two stages per pin, reset to the idle pin levels
  tcp_sync #(
    .W (12)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .rst_val  (12'hfff),
    .pin_in   ({char_in_parity_n, char_in_bus_n, char_clock,
                gap_n, error_n, skip_resp_n, halt_n}),
    .sync_out (pins_s)
  );

  wire       halt_s  = ~pins_s[0];
  wire       skip_s  = ~pins_s[1];
  wire       err_s   = ~pins_s[2];
  wire       gap_s   = ~pins_s[3];
  wire       clk_s   = pins_s[4];
  wire [5:0] in_char = ~pins_s[10:5];
  wire       in_par  = ~pins_s[11];

  reg clk_d;
  reg err_d;
  reg gap_d;
  wire clk_rise = clk_s & ~clk_d;

  // ==================================================================
  // registers and state
  reg        active;
  reg        tx_full;
  reg        rx_full;
  reg [5:0]  tx_hold;
  reg [5:0]  rx_hold;
  reg [5:0]  char_reg;
  reg        rx_par_bad;
  reg        skip_seen;
  reg [4:0]  irq_stat;
  reg [4:0]  irq_mask;
  reg [4:0]  irq_set;

  reg        aw_hold;
  reg        w_hold;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       do_write = aw_hold & w_hold & ~s_axi_bvalid;
  wire       do_read  = s_axi_arvalid & s_axi_arready;
  wire       rd_rx    = do_read && (s_axi_araddr == `TCP_RXDATA);

  wire [31:0] wr_val = merge(32'h0, w_data, w_strb);
  wire wr_ctrl = do_write && (aw_addr == `TCP_CTRL);
  wire wr_cmd  = do_write && (aw_addr == `TCP_CMD);
  wire wr_tx   = do_write && (aw_addr == `TCP_TXDATA);
  wire go      = wr_ctrl && wr_val[`TCP_CTRL_GO];
  wire stop    = wr_ctrl && wr_val[`TCP_CTRL_STOP];
  // moves only at phase zero of a computer cycle
  wire move_ok = phase_step && (phase == 3'h0);

  // ==================================================================
  // axi write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TCP_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `TCP_RESP_OK : `TCP_RESP_ERR;
      end
      // reopen address and data only once the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==================================================================
  // axi read channel, one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TCP_RESP_OK;
    end else if (do_read) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? `TCP_RESP_OK : `TCP_RESP_ERR;
      if (s_axi_araddr == `TCP_CTRL) begin
        s_axi_rdata <= {30'h0, direction_bit, 1'b0};
      end else if (s_axi_araddr == `TCP_UNIT) begin
        s_axi_rdata <= {27'h0, unit_select_bits};
      end else if (s_axi_araddr == `TCP_INSTR) begin
        s_axi_rdata <= {20'h0, instr_address_lines};
      end else if (s_axi_araddr == `TCP_TXDATA) begin
        s_axi_rdata <= {26'h0, tx_hold};
      end else if (s_axi_araddr == `TCP_RXDATA) begin
        s_axi_rdata <= {25'h0, rx_par_bad, rx_hold};
      end else if (s_axi_araddr == `TCP_STATUS) begin
        s_axi_rdata <= {23'h0, gap_s, err_s, skip_seen, rx_full, tx_full,
                        clock_seen_ff, transfer_pending_ff, halt_interlock_out,
                        active};
      end else if (s_axi_araddr == `TCP_IRQ_STAT) begin
        s_axi_rdata <= {27'h0, irq_stat};
      end else if (s_axi_araddr == `TCP_IRQ_MASK) begin
        s_axi_rdata <= {27'h0, irq_mask};
      end else begin
        s_axi_rdata <= 32'h0;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==================================================================
  // setup registers and command strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      direction_bit       <= 1'b0;
      unit_select_bits    <= `TCP_UNIT_RST;
      instr_address_lines <= `TCP_INSTR_RST;
      buffer_ctl_strobe   <= 1'b0;
      io_ctl_strobe       <= 1'b0;
      skip_seen           <= 1'b0;
      irq_mask            <= 5'h00;
    end else begin
      buffer_ctl_strobe <= wr_cmd & wr_val[`TCP_CMD_BUF];
      io_ctl_strobe     <= wr_cmd & wr_val[`TCP_CMD_IO];
      // skip answer sampled at the test
      if (wr_cmd && wr_val[`TCP_CMD_SKIP]) begin
        skip_seen <= skip_s;
      end
      if (wr_ctrl) begin
        direction_bit <= wr_val[`TCP_CTRL_DIR];
      end
      if (do_write && aw_addr == `TCP_UNIT) begin
        unit_select_bits <= wr_val[4:0];
      end
      if (do_write && aw_addr == `TCP_INSTR) begin
        instr_address_lines <= wr_val[11:0];
      end
      if (do_write && aw_addr == `TCP_IRQ_MASK) begin
        irq_mask <= wr_val[4:0];
      end
    end
  end

  // ==================================================================
  // character transfer engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      active              <= 1'b0;
      halt_interlock_out  <= 1'b0;
      transfer_pending_ff <= 1'b0;
      clock_seen_ff       <= 1'b0;
      tx_full             <= 1'b0;
      rx_full             <= 1'b0;
      tx_hold             <= 6'h00;
      rx_hold             <= 6'h00;
      char_reg            <= 6'h00;
      rx_par_bad          <= 1'b0;
      // idle clock stands high, so no false edge after reset
      clk_d               <= 1'b1;
      irq_set             <= 5'h00;
    end else begin
      clk_d   <= clk_s;
      irq_set <= 5'h00;
      if (wr_tx) begin
        tx_hold <= wr_val[5:0];
        tx_full <= 1'b1;
      end
      if (rd_rx) begin
        rx_full <= 1'b0;
      end
      if (go) begin
        active              <= 1'b1;
        clock_seen_ff       <= 1'b0;
        // output: char register empty at start, so a load is due
        transfer_pending_ff <= wr_val[`TCP_CTRL_DIR];
        halt_interlock_out  <= wr_val[`TCP_CTRL_DIR];
      end else if (active && (halt_s || stop)) begin
        active              <= 1'b0;
        halt_interlock_out  <= 1'b0;
        transfer_pending_ff <= 1'b0;
        irq_set[`TCP_IRQ_HALT] <= halt_s;
      end else if (active) begin
        if (clk_rise) begin
          clock_seen_ff       <= 1'b1;
          transfer_pending_ff <= 1'b1;
          if (!direction_bit) begin
            char_reg   <= in_char;
            rx_par_bad <= ~^{in_char, in_par};
          end
        end else if (transfer_pending_ff && move_ok) begin
          if (direction_bit && tx_full && !wr_tx) begin
            char_reg               <= tx_hold;
            tx_full                <= 1'b0;
            transfer_pending_ff    <= 1'b0;
            clock_seen_ff          <= 1'b0;
            irq_set[`TCP_IRQ_CHAR] <= 1'b1;
          end else if (!direction_bit && (!rx_full || rd_rx)) begin
            rx_hold                <= char_reg;
            rx_full                <= 1'b1;
            transfer_pending_ff    <= 1'b0;
            clock_seen_ff          <= 1'b0;
            halt_interlock_out     <= 1'b1;
            irq_set[`TCP_IRQ_CHAR] <= 1'b1;
            irq_set[`TCP_IRQ_PAR]  <= rx_par_bad;
          end
        end
      end
    end
  end

  // ==================================================================
  // character output lines
  always @(posedge aclk) begin
    if (!aresetn) begin
      char_out_bus    <= 6'h00;
      char_out_parity <= 1'b1;
    end else begin
      // bit 0 is the lsb line
      char_out_bus    <= char_reg;
      char_out_parity <= ~^char_reg;
    end
  end

  // ==================================================================
  // interrupt status, write one to clear, set wins
  wire [4:0] irq_clr = (do_write && aw_addr == `TCP_IRQ_STAT) ? wr_val[4:0] : 5'h00;
  wire [4:0] irq_ev  = irq_set | {1'b0, gap_s & ~gap_d, err_s & ~err_d, 2'b00};

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 5'h00;
      err_d    <= 1'b0;
      gap_d    <= 1'b0;
      irq      <= 1'b0;
    end else begin
      err_d    <= err_s;
      gap_d    <= gap_s;
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end
endmodule

// *** test/tcp_sva.sv ***
// pin-level checker for the tape character port
module tcp_sva #(
  parameter DIV = 4
) (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // pins watched
  input wire       halt_n,
  input wire       char_clock,
  input wire       buffer_ctl_strobe,
  input wire       io_ctl_strobe,
  input wire       halt_interlock_out,
  input wire       transfer_pending_ff,
  input wire       clock_seen_ff,
  input wire       cycle_window_timing,
  input wire [5:0] char_out_bus,
  input wire       char_out_parity
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========
  // run length of each window level
  reg       w_q;
  reg       full;
  reg [7:0] run;
  wire      w_chg = cycle_window_timing != w_q;
  // first high run after reset is partial, so it is skipped
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_q  <= 1'b1;
      full <= 1'b0;
      run  <= 8'h00;
    end else begin
      w_q  <= cycle_window_timing;
      full <= full | (w_chg & w_q);
      run  <= w_chg ? 8'h01 : run + 8'h01;
    end
  end
  // ========
  // properties
  sequence s_one(sig);
    sig ##1 !sig;
  endsequence
  property p_buc;
    buffer_ctl_strobe |-> s_one(buffer_ctl_strobe);
  endproperty
  a_buc: assert property (p_buc) else $error("buffer strobe too long");
  property p_ioc;
    io_ctl_strobe |-> s_one(io_ctl_strobe);
  endproperty
  a_ioc: assert property (p_ioc) else $error("io strobe too long");
  property p_par;
    char_out_parity == ~^char_out_bus;
  endproperty
  a_par: assert property (p_par) else $error("parity not odd");
  property p_win_lo;
    w_chg && !w_q |-> run == 2 * DIV;
  endproperty
  a_win_lo: assert property (p_win_lo) else $error("window low run");
  property p_win_hi;
    w_chg && w_q && full |-> run == 6 * DIV;
  endproperty
  a_win_hi: assert property (p_win_hi) else $error("window high run");
  property p_seen;
    $rose(char_clock) && !transfer_pending_ff |-> ##[1:6] clock_seen_ff;
  endproperty
  a_seen: assert property (p_seen) else $error("clock not seen");
  property p_pend;
    $rose(clock_seen_ff) |-> transfer_pending_ff;
  endproperty
  a_pend: assert property (p_pend) else $error("move not pending");
  property p_halt;
    $fell(halt_n) && halt_interlock_out |-> ##[1:6]
      !halt_interlock_out && !transfer_pending_ff;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
endmodule

// *** test/tcp_tape_model.sv ***
// behavioural tape unit on the far side of the port
module tcp_tape_model (
  // move pending from the port
  input  wire        pend_ff,
  // lines to the port
  output logic       halt_n,
  output logic       skip_resp_n,
  output logic       error_n,
  output logic       gap_n,
  output logic       char_clock,
  output logic [5:0] char_in_bus_n,
  output logic       char_in_parity_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock stands high, control lines released, character lines at 6'h2a
  initial begin
    halt_n = 1'b1;
    skip_resp_n = 1'b1;
    error_n = 1'b1;
    gap_n = 1'b1;
    char_clock = 1'b1;
    char_in_bus_n = 6'h2a;
    char_in_parity_n = 1'b0;
  end
  // one character, held until the port has moved it
  task send(input [5:0] c);
    begin
      // inverted data, inverted odd parity
      // called on a clock edge, so lines change after the edge samples
      char_in_bus_n <= ~c;
      char_in_parity_n <= ^c;
      #100 char_clock <= 1'b0;
      #100 char_clock <= 1'b1;
      wait (pend_ff === 1'b1);
      wait (pend_ff === 1'b0);
      char_in_bus_n <= c;
      char_in_parity_n <= ~^c;
    end
  endtask
  task halt;
    begin
      halt_n <= 1'b0;
      #400 halt_n <= 1'b1;
    end
  endtask
  task lines(input s, input e, input g);
    begin
      skip_resp_n <= s;
      error_n <= e;
      gap_n <= g;
    end
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the tape character port
`include "tcp_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DIV = 2;
  // ========
  // bus drivers, pins and counters
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [31:0] rd;
  logic [1:0]  rsp;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire  [5:0]  bus_n, cout;
  wire  [4:0]  unit;
  wire  [11:0] instr;
  wire         awready, wready, bvalid, arready, rvalid, halt_n, skip_n, err_n;
  wire         gap_n, ck, par_n, buc, ioc, ilk, pend, seen, win, dir, cpar, irq;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_buc = 0;
  int          n_ioc = 0;
  always #12.5 aclk = ~aclk;
  tcp_port #(.DIV(DIV)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .halt_n(halt_n), .skip_resp_n(skip_n), .error_n(err_n), .gap_n(gap_n),
    .char_clock(ck), .char_in_bus_n(bus_n), .char_in_parity_n(par_n),
    .buffer_ctl_strobe(buc), .io_ctl_strobe(ioc), .halt_interlock_out(ilk),
    .transfer_pending_ff(pend), .clock_seen_ff(seen), .cycle_window_timing(win),
    .direction_bit(dir), .unit_select_bits(unit), .char_out_bus(cout),
    .char_out_parity(cpar), .instr_address_lines(instr), .irq(irq));
  tcp_tape_model u_tape (
    .pend_ff(pend), .halt_n(halt_n), .skip_resp_n(skip_n), .error_n(err_n),
    .gap_n(gap_n), .char_clock(ck), .char_in_bus_n(bus_n), .char_in_parity_n(par_n));
  // ========
  // bus tasks: hold each channel until its own ready
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
    end
  endtask
  task automatic rdr(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares++;
      if (g !== e) begin
        failures++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // strobe counters and the hang limit
  always @(posedge aclk) begin
    n_buc <= n_buc + buc;
    n_ioc <= n_ioc + ioc;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  // ========
  // scenarios
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(8'h24);
    chk(rsp, `TCP_RESP_ERR);
    chk(rd, 32'h0);
    wr(`TCP_UNIT, 32'h15);
    wr(`TCP_INSTR, 32'habc);
    rdr(`TCP_INSTR);
    chk(unit, 32'h15);
    chk(instr, 32'habc);
    chk(rd, 32'habc);
    // back-to-back commands, one strobe for each command bit that is set
    for (int i = 1; i < 4; i++)
      wr(`TCP_CMD, i);
    repeat (3) @(posedge aclk);
    chk(n_buc, 2);
    chk(n_ioc, 2);
    // skip answer in both levels
    for (int s = 0; s < 2; s++) begin
      u_tape.lines(s[0], 1'b1, 1'b1);
      repeat (4) @(posedge aclk);
      wr(`TCP_CMD, 32'h4);
      rdr(`TCP_STATUS);
      chk(rd[6], !s[0]);
    end
    // output of two characters
    wr(`TCP_TXDATA, 32'h2d);
    wr(`TCP_CTRL, 32'h3);
    chk(dir, 1);
    while (pend !== 1'b1) @(posedge aclk);
    while (pend !== 1'b0) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk(cout, 32'h2d);
    chk(cpar, 1);
    wr(`TCP_TXDATA, 32'h01);
    u_tape.send(6'h01);
    repeat (2) @(posedge aclk);
    chk(cout, 32'h01);
    chk(cpar, 0);
    // interrupt masked, raised, cleared
    rdr(`TCP_IRQ_STAT);
    chk(rd[0], 1);
    chk(irq, 0);
    wr(`TCP_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    wr(`TCP_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    u_tape.halt;
    chk(ilk, 0);
    rdr(`TCP_IRQ_STAT);
    chk(rd[1], 1);
    // input of one character, then error and gap
    wr(`TCP_CTRL, 32'h1);
    chk(dir, 0);
    chk(ilk, 0);
    u_tape.send(6'h25);
    repeat (2) @(posedge aclk);
    chk(ilk, 1);
    rdr(`TCP_RXDATA);
    chk(rd[6:0], 7'h25);
    u_tape.lines(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge aclk);
    rdr(`TCP_STATUS);
    chk(rd[8:7], 2'h3);
    rdr(`TCP_IRQ_STAT);
    chk(rd[3:2], 2'h3);
    u_tape.halt;
    chk(ilk, 0);
    test_done;
  end
endmodule
bind tcp_port tcp_sva #(.DIV(DIV)) u_sva (
  .aclk(aclk), .aresetn(aresetn), .halt_n(halt_n), .char_clock(char_clock),
  .buffer_ctl_strobe(buffer_ctl_strobe), .io_ctl_strobe(io_ctl_strobe),
  .halt_interlock_out(halt_interlock_out), .transfer_pending_ff(transfer_pending_ff),
  .clock_seen_ff(clock_seen_ff), .cycle_window_timing(cycle_window_timing),
  .char_out_bus(char_out_bus), .char_out_parity(char_out_parity));
